// ===== branch_skip_bit_ops_map.vh
// constants for the branch, skip and bit-operation unit
`ifndef BRANCH_SKIP_BIT_OPS_MAP_VH
`define BRANCH_SKIP_BIT_OPS_MAP_VH

// ----------
// operation codes
// ----------
`define OP_SKIP_REG_SET    6'h00
`define OP_SKIP_IO_CLR     6'h01
`define OP_SKIP_IO_SET     6'h02
`define OP_BR_FLAG_SET     6'h03
`define OP_BR_FLAG_CLR     6'h04
`define OP_BR_EQUAL        6'h05
`define OP_BR_NOT_EQUAL    6'h06
`define OP_BR_CARRY_SET    6'h07
`define OP_BR_CARRY_CLR    6'h08
`define OP_BR_SAME_HIGHER  6'h09
`define OP_BR_LOWER        6'h0A
`define OP_BR_MINUS        6'h0B
`define OP_BR_PLUS         6'h0C
`define OP_BR_SIGNED_GE    6'h0D
`define OP_BR_SIGNED_LT    6'h0E
`define OP_BR_HALF_SET     6'h0F
`define OP_BR_HALF_CLR     6'h10
`define OP_BR_TFLAG_SET    6'h11
`define OP_BR_TFLAG_CLR    6'h12
`define OP_BR_OVF_SET      6'h13
`define OP_BR_OVF_CLR      6'h14
`define OP_BR_IRQ_ENABLED  6'h15
`define OP_BR_IRQ_DISABLED 6'h16
`define OP_IO_BIT_SET      6'h17
`define OP_IO_BIT_CLR      6'h18
`define OP_LOGIC_LEFT      6'h19
`define OP_LOGIC_RIGHT     6'h1A
`define OP_ROTATE_LEFT     6'h1B
`define OP_ROTATE_RIGHT    6'h1C
`define OP_ARITH_RIGHT     6'h1D
`define OP_NIBBLE_SWAP     6'h1E
`define OP_STATUS_BIT_SET  6'h1F
`define OP_STATUS_BIT_CLR  6'h20
`define OP_REG_TO_TFLAG    6'h21
`define OP_TFLAG_TO_REG    6'h22
`define OP_CARRY_SET       6'h23
`define OP_CARRY_CLR       6'h24
`define OP_NEGATIVE_SET    6'h25
`define OP_NEGATIVE_CLR    6'h26
`define OP_ZERO_SET        6'h27
`define OP_ZERO_CLR        6'h28
`define OP_GLOBAL_IRQ_ON   6'h29

// ----------
// status flag positions
// ----------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ----------
// register map and reset values
// ----------
`define ADDR_FLAGS      2'h0
`define ADDR_PC         2'h1
`define ADDR_INFO       2'h2
`define FLAGS_RESET     8'h00
`define INFO_BUSY       0
`define INFO_TAKEN      1
`define INFO_CYC_LO     2
`define INFO_CYC_HI     3

// ----------
// program counter steps and cycle counts
// ----------
`define PC_STEP_NEXT    1
`define PC_STEP_SKIP1   2
`define PC_STEP_SKIP2   3
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

`endif

// ===== branch_skip_bit_ops_unit.v
// execution of skip, branch, shift and flag-bit instructions
//
// Function
// - skip next instruction when chosen register bit is one; flags untouched.
// - skip next instruction when chosen io register bit is zero; flags untouched.
// - skip next instruction when chosen io register bit is one; flags untouched.
// - generic branches test the flag chosen by s, taken goes to pc+k+1.
// - equal branches on zero flag one, not-equal on zero flag zero.
// - carry-set and lower on carry one; carry-clear and same-or-higher on zero.
// - minus branches on negative one, plus branches on negative zero.
// - signed ge branches when n xor v is zero, signed lt when one.
// - half-carry set and clear branches test the half-carry flag.
// - t flag set and clear branches test the t flag.
// - overflow set and clear branches test the overflow flag.
// - irq enabled and disabled branches test the global interrupt flag.
// - set or clear one io register bit in two cycles, nothing else changes.
// - logical left shift loads zero in bit 0, updates z c n v.
// - logical right shift loads zero in bit 7, updates z c n v.
// - rotates pass the old carry in and the outgoing bit to carry.
// - arithmetic right shift keeps bit 7, updates z c n v.
// - nibble swap exchanges register halves, flags untouched, one cycle.
// - store register bit into t; load t into register bit; one cycle.
// - single-cycle set or clear of one flag, only that flag changes.
`timescale 1ns/100ps
`include "branch_skip_bit_ops_map.vh"

module branch_skip_bit_ops_unit #(
    parameter PC_W  = 16,
    parameter OFS_W = 7
) (
    input  wire             i_clk,
    input  wire             i_reset_n,
    input  wire             i_wb_cyc,
    input  wire             i_wb_stb,
    input  wire             i_wb_we,
    input  wire [3:0]       i_wb_adr,
    input  wire [31:0]      i_wb_dat,
    input  wire [3:0]       i_wb_sel,
    output wire [31:0]      o_wb_dat,
    output wire             o_wb_ack,
    input  wire             i_op_valid,
    output wire             o_op_ready,
    input  wire [5:0]       i_op_code,
    input  wire [2:0]       i_op_bit,
    input  wire [OFS_W-1:0] i_op_offset,
    input  wire             i_op_two_word_next,
    input  wire [7:0]       i_reg_data,
    input  wire [7:0]       i_io_data,
    output wire             o_reg_we,
    output wire [7:0]       o_reg_wdata,
    output wire             o_io_we,
    output wire [7:0]       o_io_wdata,
    output wire             o_done,
    output wire [PC_W-1:0]  o_pc,
    output wire [7:0]       o_flags
);

    // ----------
    // constants
    // ----------
    localparam [PC_W-1:0] PC_NEXT  = `PC_STEP_NEXT;
    localparam [PC_W-1:0] PC_SKIP1 = `PC_STEP_SKIP1;
    localparam [PC_W-1:0] PC_SKIP2 = `PC_STEP_SKIP2;

    // ----------
    // state
    // ----------
    reg [7:0]      flags_r;
    reg [PC_W-1:0] pc_r;
    reg [1:0]      remain_r;
    reg            taken_r;
    reg [1:0]      last_cyc_r;
    reg            reg_we_r;
    reg [7:0]      reg_wdata_r;
    reg            io_we_r;
    reg [7:0]      io_wdata_r;
    reg            done_r;
    reg            ack_r;
    reg [31:0]     wb_dat_r;

    reg [7:0]      flags_nxt;
    reg [PC_W-1:0] pc_nxt;
    reg [1:0]      cyc_nxt;
    reg            taken_nxt;
    reg            reg_we_nxt;
    reg [7:0]      reg_wdata_nxt;
    reg            io_we_nxt;
    reg [7:0]      io_wdata_nxt;

    wire           accept;
    wire           bus_req;
    wire           bus_wr;
    wire [PC_W-1:0] ofs_ext;

    // ----------
    // functions
    // ----------
    // flag result of a shift or rotate
    function [7:0] shift_flags;
        input [7:0] f;
        input [7:0] res;
        input       c;
        reg   [7:0] t;
        begin
            t = f;
            t[`FLAG_C] = c;
            t[`FLAG_Z] = (res == 8'h00);
            t[`FLAG_N] = res[7];
            t[`FLAG_V] = res[7] ^ c;
            shift_flags = t;
        end
    endfunction

    // branch condition for every branch code
    function branch_cond;
        input [5:0] op;
        input [2:0] s;
        input [7:0] f;
        begin
            case (op)
                `OP_BR_FLAG_SET: branch_cond = f[s];
                `OP_BR_FLAG_CLR: branch_cond = ~f[s];
                `OP_BR_EQUAL: branch_cond = f[`FLAG_Z];
                `OP_BR_NOT_EQUAL: branch_cond = ~f[`FLAG_Z];
                `OP_BR_CARRY_SET: branch_cond = f[`FLAG_C];
                `OP_BR_LOWER: branch_cond = f[`FLAG_C];
                `OP_BR_CARRY_CLR: branch_cond = ~f[`FLAG_C];
                `OP_BR_SAME_HIGHER: branch_cond = ~f[`FLAG_C];
                `OP_BR_MINUS: branch_cond = f[`FLAG_N];
                `OP_BR_PLUS: branch_cond = ~f[`FLAG_N];
                `OP_BR_SIGNED_GE: branch_cond = ~(f[`FLAG_N] ^ f[`FLAG_V]);
                `OP_BR_SIGNED_LT: branch_cond = f[`FLAG_N] ^ f[`FLAG_V];
                `OP_BR_HALF_SET: branch_cond = f[`FLAG_H];
                `OP_BR_HALF_CLR: branch_cond = ~f[`FLAG_H];
                `OP_BR_TFLAG_SET: branch_cond = f[`FLAG_T];
                `OP_BR_TFLAG_CLR: branch_cond = ~f[`FLAG_T];
                `OP_BR_OVF_SET: branch_cond = f[`FLAG_V];
                `OP_BR_OVF_CLR: branch_cond = ~f[`FLAG_V];
                `OP_BR_IRQ_ENABLED: branch_cond = f[`FLAG_I];
                `OP_BR_IRQ_DISABLED: branch_cond = ~f[`FLAG_I];
                default: branch_cond = 1'b0;
            endcase
        end
    endfunction

    // true for every branch code
    function is_branch;
        input [5:0] op;
        begin
            is_branch = (op >= `OP_BR_FLAG_SET) && (op <= `OP_BR_IRQ_DISABLED);
        end
    endfunction

    // ----------
    // operation handshake
    // ----------
    assign o_op_ready = (remain_r == 2'h0);
    assign accept     = i_op_valid & o_op_ready;
    assign ofs_ext    = {{(PC_W-OFS_W){i_op_offset[OFS_W-1]}}, i_op_offset};

    // ----------
    // execution
    // ----------
    always @* begin
        flags_nxt     = flags_r;
        pc_nxt        = pc_r + PC_NEXT;
        cyc_nxt       = `CYC_ONE;
        taken_nxt     = 1'b0;
        reg_we_nxt    = 1'b0;
        reg_wdata_nxt = i_reg_data;
        io_we_nxt     = 1'b0;
        io_wdata_nxt  = i_io_data;
        case (i_op_code)
            `OP_SKIP_REG_SET: begin
                taken_nxt = i_reg_data[i_op_bit];
            end
            `OP_SKIP_IO_CLR: begin
                taken_nxt = ~i_io_data[i_op_bit];
            end
            `OP_SKIP_IO_SET: begin
                taken_nxt = i_io_data[i_op_bit];
            end
            `OP_IO_BIT_SET: begin
                io_we_nxt              = 1'b1;
                io_wdata_nxt[i_op_bit] = 1'b1;
                cyc_nxt                = `CYC_TWO;
            end
            `OP_IO_BIT_CLR: begin
                io_we_nxt              = 1'b1;
                io_wdata_nxt[i_op_bit] = 1'b0;
                cyc_nxt                = `CYC_TWO;
            end
            `OP_LOGIC_LEFT: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {i_reg_data[6:0], 1'b0};
                flags_nxt     = shift_flags(flags_r, reg_wdata_nxt, i_reg_data[7]);
            end
            `OP_LOGIC_RIGHT: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {1'b0, i_reg_data[7:1]};
                flags_nxt     = shift_flags(flags_r, reg_wdata_nxt, i_reg_data[0]);
            end
            `OP_ROTATE_LEFT: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {i_reg_data[6:0], flags_r[`FLAG_C]};
                flags_nxt     = shift_flags(flags_r, reg_wdata_nxt, i_reg_data[7]);
            end
            `OP_ROTATE_RIGHT: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {flags_r[`FLAG_C], i_reg_data[7:1]};
                flags_nxt     = shift_flags(flags_r, reg_wdata_nxt, i_reg_data[0]);
            end
            `OP_ARITH_RIGHT: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {i_reg_data[7], i_reg_data[7:1]};
                flags_nxt     = shift_flags(flags_r, reg_wdata_nxt, i_reg_data[0]);
            end
            `OP_NIBBLE_SWAP: begin
                reg_we_nxt    = 1'b1;
                reg_wdata_nxt = {i_reg_data[3:0], i_reg_data[7:4]};
            end
            `OP_REG_TO_TFLAG: begin
                flags_nxt[`FLAG_T] = i_reg_data[i_op_bit];
            end
            `OP_TFLAG_TO_REG: begin
                reg_we_nxt              = 1'b1;
                reg_wdata_nxt[i_op_bit] = flags_r[`FLAG_T];
            end
            `OP_STATUS_BIT_SET: begin
                flags_nxt[i_op_bit] = 1'b1;
            end
            `OP_STATUS_BIT_CLR: begin
                flags_nxt[i_op_bit] = 1'b0;
            end
            `OP_CARRY_SET: begin
                flags_nxt[`FLAG_C] = 1'b1;
            end
            `OP_CARRY_CLR: begin
                flags_nxt[`FLAG_C] = 1'b0;
            end
            `OP_NEGATIVE_SET: begin
                flags_nxt[`FLAG_N] = 1'b1;
            end
            `OP_NEGATIVE_CLR: begin
                flags_nxt[`FLAG_N] = 1'b0;
            end
            `OP_ZERO_SET: begin
                flags_nxt[`FLAG_Z] = 1'b1;
            end
            `OP_ZERO_CLR: begin
                flags_nxt[`FLAG_Z] = 1'b0;
            end
            `OP_GLOBAL_IRQ_ON: begin
                flags_nxt[`FLAG_I] = 1'b1;
            end
            default: begin
                taken_nxt = branch_cond(i_op_code, i_op_bit, flags_r);
            end
        endcase
        // skip: two or three words, two or three cycles
        if (taken_nxt && (i_op_code <= `OP_SKIP_IO_SET)) begin
            if (i_op_two_word_next) begin
                pc_nxt  = pc_r + PC_SKIP2;
                cyc_nxt = `CYC_THREE;
            end else begin
                pc_nxt  = pc_r + PC_SKIP1;
                cyc_nxt = `CYC_TWO;
            end
        end
        // taken branch: pc+k+1, one extra cycle
        if (taken_nxt && is_branch(i_op_code)) begin
            pc_nxt  = pc_r + ofs_ext + PC_NEXT;
            cyc_nxt = `CYC_TWO;
        end
    end

    // ----------
    // wishbone slave
    // ----------
    assign bus_req  = i_wb_cyc & i_wb_stb;
    assign bus_wr   = bus_req & i_wb_we & ack_r;
    assign o_wb_ack = ack_r;
    assign o_wb_dat = wb_dat_r;

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            ack_r    <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            ack_r    <= bus_req & ~ack_r;
            wb_dat_r <= 32'h0000_0000;
            if (bus_req && !ack_r && !i_wb_we) begin
                case (i_wb_adr[3:2])
                    `ADDR_FLAGS: wb_dat_r[7:0]      <= flags_r;
                    `ADDR_PC:    wb_dat_r[PC_W-1:0] <= pc_r;
                    `ADDR_INFO: begin
                        wb_dat_r[`INFO_BUSY]                 <= ~o_op_ready;
                        wb_dat_r[`INFO_TAKEN]                <= taken_r;
                        wb_dat_r[`INFO_CYC_HI:`INFO_CYC_LO]  <= last_cyc_r;
                    end
                    default:     wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------
    // core state
    // ----------
    integer i;

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            flags_r     <= `FLAGS_RESET;
            pc_r        <= {PC_W{1'b0}};
            remain_r    <= 2'h0;
            taken_r     <= 1'b0;
            last_cyc_r  <= 2'h0;
            reg_we_r    <= 1'b0;
            reg_wdata_r <= 8'h00;
            io_we_r     <= 1'b0;
            io_wdata_r  <= 8'h00;
            done_r      <= 1'b0;
        end else begin
            reg_we_r <= 1'b0;
            io_we_r  <= 1'b0;
            done_r   <= 1'b0;
            if (accept) begin
                flags_r    <= flags_nxt;
                pc_r       <= pc_nxt;
                taken_r    <= taken_nxt;
                last_cyc_r <= cyc_nxt;
                remain_r   <= cyc_nxt - `CYC_ONE;
                reg_we_r   <= reg_we_nxt;
                io_we_r    <= io_we_nxt;
                done_r     <= (cyc_nxt == `CYC_ONE);
                if (reg_we_nxt) begin
                    reg_wdata_r <= reg_wdata_nxt;
                end
                if (io_we_nxt) begin
                    io_wdata_r <= io_wdata_nxt;
                end
            end else if (remain_r != 2'h0) begin
                remain_r <= remain_r - `CYC_ONE;
                done_r   <= (remain_r == `CYC_ONE);
            end
            // bus writes take effect at the acknowledge edge
            if (bus_wr && (i_wb_adr[3:2] == `ADDR_FLAGS) && i_wb_sel[0]) begin
                flags_r <= i_wb_dat[7:0];
            end
            if (bus_wr && (i_wb_adr[3:2] == `ADDR_PC)) begin
                for (i = 0; i < PC_W; i = i + 1) begin
                    if (i_wb_sel[i/8]) begin
                        pc_r[i] <= i_wb_dat[i];
                    end
                end
            end
        end
    end

    // ----------
    // outputs
    // ----------
    assign o_reg_we    = reg_we_r;
    assign o_reg_wdata = reg_wdata_r;
    assign o_io_we     = io_we_r;
    assign o_io_wdata  = io_wdata_r;
    assign o_done      = done_r;
    assign o_pc        = pc_r;
    assign o_flags     = flags_r;

endmodule // branch_skip_bit_ops_unit

// ===== bsb_unit_assertions.sv
// concurrent checks on the ports of the branch, skip and bit-operation unit
`timescale 1ns/100ps
`include "branch_skip_bit_ops_map.vh"
module bsb_checker #(
    parameter PC_W  = 16,
    parameter OFS_W = 7
) (
    input wire             i_clk,
    input wire             i_reset_n,
    input wire             i_wb_cyc,
    input wire             i_wb_stb,
    input wire             i_wb_we,
    input wire [31:0]      o_wb_dat,
    input wire             o_wb_ack,
    input wire             i_op_valid,
    input wire             o_op_ready,
    input wire [5:0]       i_op_code,
    input wire [2:0]       i_op_bit,
    input wire [OFS_W-1:0] i_op_offset,
    input wire             i_op_two_word_next,
    input wire [7:0]       i_reg_data,
    input wire [7:0]       i_io_data,
    input wire             o_reg_we,
    input wire [7:0]       o_reg_wdata,
    input wire             o_io_we,
    input wire [7:0]       o_io_wdata,
    input wire             o_done,
    input wire [PC_W-1:0]  o_pc,
    input wire [7:0]       o_flags
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ----------
    // accepted operation, sign-extended offset
    // ----------
    wire            go = i_op_valid && o_op_ready && !(i_wb_cyc && i_wb_stb && i_wb_we);
    wire [PC_W-1:0] kx = {{(PC_W-OFS_W){i_op_offset[OFS_W-1]}}, i_op_offset};
    wire [5:0]      op = i_op_code;
    ack_pulse_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not one pulse");
    rdata_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("stray read data");
    skip_reg_a: assert property (go && op == `OP_SKIP_REG_SET && i_reg_data[i_op_bit]
        |=> o_pc == $past(o_pc + 2 + i_op_two_word_next) && $stable(o_flags) && !o_op_ready)
        else $error("reg skip");
    skip_io_a: assert property (go && ((op == `OP_SKIP_IO_CLR && !i_io_data[i_op_bit])
        || (op == `OP_SKIP_IO_SET && i_io_data[i_op_bit]))
        |=> o_pc == $past(o_pc + 2 + i_op_two_word_next) && $stable(o_flags))
        else $error("io skip");
    branch_any_a: assert property (go && op >= `OP_BR_FLAG_SET && op <= `OP_BR_IRQ_DISABLED
        |=> $stable(o_flags)
        && (o_pc == $past(PC_W'(o_pc + 1)) || o_pc == $past(PC_W'(o_pc + kx + 1))))
        else $error("branch wrong");
    branch_eq_a: assert property (go && ((op == `OP_BR_EQUAL && o_flags[`FLAG_Z])
        || (op == `OP_BR_NOT_EQUAL && !o_flags[`FLAG_Z]))
        |=> o_pc == $past(PC_W'(o_pc + kx + 1)) && !o_op_ready ##1 o_done && o_op_ready)
        else $error("equal branch");
    signed_ge_a: assert property (go && op == `OP_BR_SIGNED_GE
        && !(o_flags[`FLAG_N] ^ o_flags[`FLAG_V]) |=> o_pc == $past(PC_W'(o_pc + kx + 1)))
        else $error("signed branch");
    io_bit_a: assert property (go && op == `OP_IO_BIT_SET |=> o_io_we
        && o_io_wdata == $past(i_io_data | (8'h01 << i_op_bit)) && $stable(o_flags) ##1 o_done)
        else $error("io bit set");
    left_shift_a: assert property (go && op == `OP_LOGIC_LEFT |=> o_reg_we && o_done
        && o_reg_wdata == {$past(i_reg_data[6:0]), 1'b0} && o_flags[0] == $past(i_reg_data[7]))
        else $error("left shift");
    nibble_swap_a: assert property (go && op == `OP_NIBBLE_SWAP |=> $stable(o_flags)
        && o_reg_wdata == {$past(i_reg_data[3:0]), $past(i_reg_data[7:4])})
        else $error("nibble swap");
endmodule // bsb_checker

bind branch_skip_bit_ops_unit bsb_checker #(.PC_W(PC_W), .OFS_W(OFS_W)) i_chk (.i_clk,
    .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack, .i_op_valid, .o_op_ready,
    .i_op_code, .i_op_bit, .i_op_offset, .i_op_two_word_next, .i_reg_data, .i_io_data,
    .o_reg_we, .o_reg_wdata, .o_io_we, .o_io_wdata, .o_done, .o_pc, .o_flags);

// ===== tb_top.sv
// self-checking bench for the branch, skip and bit-operation unit
`timescale 1ns/100ps
`include "branch_skip_bit_ops_map.vh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        valid = 1'b0;
    logic [5:0]  code = 6'h00;
    logic [2:0]  bitn = 3'h0;
    logic [6:0]  ofs = 7'h00;
    logic        two = 1'b0;
    logic [7:0]  rd = 8'h00;
    logic [7:0]  io = 8'h00;
    logic [31:0] rdat, q;
    logic        ack, ready, rwe, iwe, done, rwe1, iwe1;
    logic [7:0]  rwd, iwd, flags, fl1, rwd1, iwd1;
    logic [15:0] pc, pc1;
    int          ncyc;
    int          miscompares = 0;
    int          total_checks = 0;
    always #4 clk = ~clk;
    branch_skip_bit_ops_unit i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_op_valid(valid), .o_op_ready(ready),
        .i_op_code(code), .i_op_bit(bitn), .i_op_offset(ofs), .i_op_two_word_next(two),
        .i_reg_data(rd), .i_io_data(io), .o_reg_we(rwe), .o_reg_wdata(rwd), .o_io_we(iwe),
        .o_io_wdata(iwd), .o_done(done), .o_pc(pc), .o_flags(flags));
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input string what, logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, logic [3:0] a, logic [31:0] d, logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        chk("bus ack", 1, n < 16);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setup(input logic [7:0] f, input logic [15:0] p);
        wb(1'b1, 4'h0, {24'h0, f}, 4'h1);
        wb(1'b1, 4'h4, {16'h0, p}, 4'h3);
    endtask
    task automatic exec(input logic [5:0] c, logic [2:0] b, logic [6:0] k, logic t,
                        logic [7:0] r, i);
        code <= c;
        bitn <= b;
        ofs <= k;
        two <= t;
        rd <= r;
        io <= i;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        ncyc = 0;
        do begin
            @(posedge clk);
            ncyc++;
            if (ncyc == 1) begin
                pc1 = pc;
                fl1 = flags;
                rwe1 = rwe;
                rwd1 = rwd;
                iwe1 = iwe;
                iwd1 = iwd;
            end
        end while (done !== 1'b1 && ncyc < 8);
    endtask
    function automatic logic taken(input logic [5:0] c, logic [7:0] f, logic [2:0] s);
        case (c)
            `OP_BR_FLAG_SET: return f[s];
            `OP_BR_FLAG_CLR: return !f[s];
            `OP_BR_EQUAL: return f[`FLAG_Z];
            `OP_BR_NOT_EQUAL: return !f[`FLAG_Z];
            `OP_BR_CARRY_SET, `OP_BR_LOWER: return f[`FLAG_C];
            `OP_BR_CARRY_CLR, `OP_BR_SAME_HIGHER: return !f[`FLAG_C];
            `OP_BR_MINUS: return f[`FLAG_N];
            `OP_BR_PLUS: return !f[`FLAG_N];
            `OP_BR_SIGNED_GE: return !(f[`FLAG_N] ^ f[`FLAG_V]);
            `OP_BR_SIGNED_LT: return f[`FLAG_N] ^ f[`FLAG_V];
            `OP_BR_HALF_SET: return f[`FLAG_H];
            `OP_BR_HALF_CLR: return !f[`FLAG_H];
            `OP_BR_TFLAG_SET: return f[`FLAG_T];
            `OP_BR_TFLAG_CLR: return !f[`FLAG_T];
            `OP_BR_OVF_SET: return f[`FLAG_V];
            `OP_BR_OVF_CLR: return !f[`FLAG_V];
            `OP_BR_IRQ_ENABLED: return f[`FLAG_I];
            default: return !f[`FLAG_I];
        endcase
    endfunction
    // ----------
    // scenarios
    // ----------
    task automatic reset_case();
        @(posedge clk);
        chk("reset pc", 0, pc);
        chk("reset flags", 0, flags);
        chk("reset ready", 1, ready);
        wb(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, 4'hC, 32'h0, 4'hF);
        chk("unmapped read", 0, q);
        setup(8'h5A, 16'h1234);
        wb(1'b1, 4'h4, 32'h000000AB, 4'h1);
        wb(1'b0, 4'h4, 32'h0, 4'hF);
        chk("pc lane write", 32'h000012AB, q);
        wb(1'b0, 4'h0, 32'h0, 4'hF);
        chk("flags read", 32'h0000005A, q);
    endtask
    task automatic branch_case();
        logic [7:0]  pat [4] = '{8'h00, 8'hFF, 8'h24, 8'h89};
        logic [6:0]  k;
        logic [2:0]  s;
        logic        tk;
        for (int p = 0; p < 4; p++) begin
            for (logic [5:0] c = `OP_BR_FLAG_SET; c <= `OP_BR_IRQ_DISABLED; c++) begin
                k = p[0] ? 7'h05 : 7'h7D;
                s = {p[1:0], 1'b1};
                tk = taken(c, pat[p], s);
                setup(pat[p], 16'h0040);
                exec(c, s, k, 1'b0, 8'h00, 8'h00);
                chk("branch pc", tk ? 16'(16'h0041 + {{9{k[6]}}, k}) : 16'h0041, pc1);
                chk("branch cycles", tk ? 2 : 1, ncyc);
                chk("branch flags", pat[p], fl1);
            end
        end
    endtask
    task automatic skip_case(input logic [5:0] c, logic [7:0] r, i, logic [2:0] b, logic t,
                             int step);
        setup(8'hA5, 16'h0100);
        exec(c, b, 7'h00, t, r, i);
        chk("skip pc", 16'h0100 + step, pc1);
        chk("skip cycles", step, ncyc);
        chk("skip flags", 8'hA5, fl1);
    endtask
    task automatic io_case(input logic [5:0] c, logic [2:0] b, logic [7:0] exp);
        setup(8'h3C, 16'h0010);
        exec(c, b, 7'h00, 1'b0, 8'h00, 8'h5A);
        chk("io write pulse", 1, iwe1);
        chk("io data", exp, iwd1);
        chk("io cycles", 2, ncyc);
        chk("io flags", 8'h3C, fl1);
    endtask
    task automatic shift_case(input logic [5:0] c, logic [7:0] r, logic ci, logic [7:0] res,
                              logic co);
        logic n;
        n = res[7];
        setup({7'h38, ci}, 16'h0020);
        exec(c, 3'h0, 7'h00, 1'b0, r, 8'h00);
        chk("shift result", res, rwd1);
        chk("shift flags", {4'h7, n ^ co, n, res == 8'h00, co}, fl1);
        chk("shift timing", {rwe1, 8'(ncyc)}, 9'h101);
    endtask
    task automatic flag_case(input logic [5:0] c, logic [2:0] s, logic [7:0] f0, f1, r, res);
        setup(f0, 16'h0030);
        exec(c, s, 7'h00, 1'b0, r, 8'h00);
        chk("flag op flags", f1, fl1);
        chk("flag op cycles", 1, ncyc);
        if (res !== 8'h00) chk("bit op result", res, rwd1);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        reset_case();
        branch_case();
        skip_case(`OP_SKIP_REG_SET, 8'h10, 8'h00, 3'h4, 1'b0, 2);
        skip_case(`OP_SKIP_REG_SET, 8'hEF, 8'h00, 3'h4, 1'b1, 1);
        skip_case(`OP_SKIP_IO_CLR, 8'h00, 8'hFB, 3'h2, 1'b1, 3);
        skip_case(`OP_SKIP_IO_CLR, 8'h00, 8'h04, 3'h2, 1'b0, 1);
        skip_case(`OP_SKIP_IO_SET, 8'h00, 8'h80, 3'h7, 1'b1, 3);
        skip_case(`OP_SKIP_IO_SET, 8'h00, 8'h80, 3'h7, 1'b0, 2);
        io_case(`OP_IO_BIT_SET, 3'h0, 8'h5B);
        io_case(`OP_IO_BIT_CLR, 3'h6, 8'h1A);
        shift_case(`OP_LOGIC_LEFT, 8'h81, 1'b0, 8'h02, 1'b1);
        shift_case(`OP_LOGIC_RIGHT, 8'h81, 1'b1, 8'h40, 1'b1);
        shift_case(`OP_ROTATE_LEFT, 8'h80, 1'b0, 8'h00, 1'b1);
        shift_case(`OP_ROTATE_LEFT, 8'h41, 1'b1, 8'h83, 1'b0);
        shift_case(`OP_ROTATE_RIGHT, 8'h01, 1'b1, 8'h80, 1'b1);
        shift_case(`OP_ARITH_RIGHT, 8'h82, 1'b0, 8'hC1, 1'b0);
        flag_case(`OP_NIBBLE_SWAP, 3'h0, 8'hA5, 8'hA5, 8'h3C, 8'hC3);
        flag_case(`OP_REG_TO_TFLAG, 3'h3, 8'h00, 8'h40, 8'h08, 8'h00);
        flag_case(`OP_TFLAG_TO_REG, 3'h2, 8'h40, 8'h40, 8'h00, 8'h04);
        flag_case(`OP_TFLAG_TO_REG, 3'h0, 8'h00, 8'h00, 8'hFF, 8'hFE);
        for (int s = 0; s < 8; s++) begin
            flag_case(`OP_STATUS_BIT_SET, 3'(s), 8'h00, 8'h01 << s, 8'h00, 8'h00);
            flag_case(`OP_STATUS_BIT_CLR, 3'(s), 8'hFF, ~(8'h01 << s), 8'h00, 8'h00);
        end
        flag_case(`OP_CARRY_SET, 3'h0, 8'h00, 8'h01, 8'h00, 8'h00);
        flag_case(`OP_CARRY_CLR, 3'h0, 8'hFF, 8'hFE, 8'h00, 8'h00);
        flag_case(`OP_NEGATIVE_SET, 3'h0, 8'h00, 8'h04, 8'h00, 8'h00);
        flag_case(`OP_NEGATIVE_CLR, 3'h0, 8'hFF, 8'hFB, 8'h00, 8'h00);
        flag_case(`OP_ZERO_SET, 3'h0, 8'h00, 8'h02, 8'h00, 8'h00);
        flag_case(`OP_ZERO_CLR, 3'h0, 8'hFF, 8'hFD, 8'h00, 8'h00);
        flag_case(`OP_GLOBAL_IRQ_ON, 3'h0, 8'h00, 8'h80, 8'h00, 8'h00);
        finish_test();
    end
endmodule // tb_top
